// file: verif/jtcfg_host_model.sv
// Host model of the test port: drives test clock, mode select and data in
`timescale 1ns/1ps
module jtcfg_host_model (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b0;
    tdi_o = 1'b0;
  end
  // One 400 ns test clock period; the clock stands still low between calls
  task automatic step(input logic m, input logic d, output logic q);
    #7 tms_o = m;
    tdi_o = d;
    // Both test clock edges fall between system clock edges, never on one
    #190 tck_o = 1'b1;
    q = tdo_i;
    // Held past the synchroniser's sampling window, then the line shows the inverse
    #100 tdi_o = ~d;
    #90 tck_o = 1'b0;
    #13;
  endtask
  // From run/idle: n bits LSB first, a pause after bit p, back to run/idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din, input int p,
                      output logic [127:0] dout);
    logic q;
    dout = '0;
    for (int j = ir ? 0 : 1; j < 4; j++) begin
      step(j < 2, 1'b0, q);
    end
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == p, din[i], q);
      dout[i] = q;
      for (int j = 0; j < 4 && i == p && i < n - 1; j++) begin
        step(j == 2, 1'b0, q);
      end
    end
    for (int j = 0; j < 3; j++) begin
      step(j == 0, 1'b0, q);
    end
  endtask
  // Five edges with mode select high reach reset from any state
  task automatic tlr;
    logic q;
    for (int j = 0; j < 6; j++) begin
      step(j < 5, 1'b0, q);
    end
  endtask
endmodule

// file: verif/jtcfg_top_sva.sv
// Checker: port-level timing and ordering of the test access port
`timescale 1ns/1ps
module jtcfg_top_chk
  import jtcfg_pkg::*;
(
  input wire logic             CLOCK_I,
  input wire logic             NRST_I,
  input wire logic             TCK_I,
  input wire logic             TDO_O,
  input wire logic             TDO_OE_N_O,
  input wire logic [BSR_W-1:0] PINS_O,
  input wire logic             PINS_TEST_O,
  input wire logic             PROG_MODE_O,
  input wire logic             LOCKED_O,
  input wire logic             BUSY_O
);
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!NRST_I);

  a_reset_clears: assert property (disable iff (1'b0)
    !NRST_I |=> TDO_OE_N_O && !PROG_MODE_O && !LOCKED_O && !BUSY_O)
    else $error("outputs not cleared by reset");
  // Test clock edges are found a few cycles late, so look two cycles back
  a_tdo_on_fall: assert property ($changed(TDO_O) |-> !$past(TCK_I, 2))
    else $error("data out moved while test clock high");
  a_oe_on_fall: assert property ($changed(TDO_OE_N_O) |-> !$past(TCK_I, 2))
    else $error("output enable moved while test clock high");
  a_instr_on_rise: assert property ($changed(PROG_MODE_O) |-> $past(TCK_I, 2))
    else $error("programming mode moved while test clock low");
  a_pins_on_rise: assert property (
    $changed(PINS_O) || $changed(PINS_TEST_O) |-> $past(TCK_I, 2))
    else $error("pin update while test clock low");
  a_op_on_rise: assert property (
    $rose(BUSY_O) || $changed(LOCKED_O) |-> $past(TCK_I, 2))
    else $error("operation started while test clock low");
  a_op_needs_prog: assert property ($rose(LOCKED_O) || BUSY_O |-> PROG_MODE_O)
    else $error("write outside programming mode");
  a_lock_clear_prog: assert property ($fell(LOCKED_O) |-> PROG_MODE_O)
    else $error("lock cleared outside programming mode");

  c_col_write: cover property (BUSY_O);
  c_lock_set: cover property ($rose(LOCKED_O));
  c_shift: cover property ($fell(TDO_OE_N_O));
endmodule

bind jtcfg_top jtcfg_top_chk u_chk (
  .CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .TCK_I(TCK_I), .TDO_O(TDO_O),
  .TDO_OE_N_O(TDO_OE_N_O), .PINS_O(PINS_O), .PINS_TEST_O(PINS_TEST_O),
  .PROG_MODE_O(PROG_MODE_O), .LOCKED_O(LOCKED_O), .BUSY_O(BUSY_O)
);

// file: verif/tb_top.sv
// Self-checking bench of the test access and configuration port
`timescale 1ns/1ps
module tb_top
  import jtcfg_pkg::*;
;
  logic             clk, nrst, ce, tck, tms, tdi, tdo, q;
  logic             tdo_oe_n, pins_test, prog_mode, locked, busy;
  logic [BSR_W-1:0] pins_in, pins_out;
  logic [127:0]     rnd, got;
  logic [88:0]      mdl_col [int];
  int               mdl_sig;
  int               busy_cnt = 0;
  int               seed = 32'h0000_5374;
  int               err_count = 0;
  int               samples_checked = 0;

  jtcfg_top u_dut (
    .CLOCK_I(clk), .NRST_I(nrst), .CE_I(ce), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
    .PINS_I(pins_in), .TDO_O(tdo), .TDO_OE_N_O(tdo_oe_n), .PINS_O(pins_out),
    .PINS_TEST_O(pins_test), .PROG_MODE_O(prog_mode), .LOCKED_O(locked), .BUSY_O(busy)
  );
  jtcfg_host_model u_host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (busy === 1'b1) begin
      busy_cnt <= busy_cnt + 1;
    end
  end

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic roll;
    rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
  endtask
  // Every instruction scan also checks what the instruction stage captured
  task automatic ir(input logic [7:0] code);
    u_host.scan(1'b1, IR_W, {120'h0, code}, -1, got);
    check("ir capture", got, IR_CAPTURE);
  endtask
  task automatic dr(input int n, input logic [127:0] din, input int p = -1);
    u_host.scan(1'b0, n, din, p, got);
  endtask
  task automatic scan_rd(input string what, input logic [7:0] code, input int n,
                         input logic [127:0] din, input logic [127:0] exp);
    ir(code);
    dr(n, din);
    check(what, got, exp);
  endtask

  initial begin
    nrst <= 1'b0;
    ce <= 1'b1;
    pins_in <= '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // Scans start from run/idle, so leave reset first
    u_host.step(1'b0, 1'b0, q);
    dr(ID_W, '0);
    check("id blind", got, ID_WORD);
    ir(INS_IDREAD);
    dr(ID_W, '0, 13);
    check("id paused", got, ID_WORD);
    for (int k = 0; k < 4; k++) begin
      roll();
      scan_rd("bypass", {1'b1, rnd[14:8]}, 8, rnd, {rnd[6:0], 1'b0});
    end
    // Abandon a data scan midway with mode select held high
    u_host.step(1'b1, 1'b0, q);
    u_host.step(1'b0, 1'b0, q);
    u_host.step(1'b0, 1'b0, q);
    repeat (6) @(posedge clk);
    check("oe in shift", tdo_oe_n, 1'b0);
    u_host.tlr();
    dr(ID_W, '0);
    check("id after tms reset", got, ID_WORD);
    for (int k = 0; k < 2; k++) begin
      roll();
      @(posedge clk);
      pins_in <= rnd[31:16];
      scan_rd("pin capture", k ? INS_EXTEST : INS_SAMPLE, BSR_W, rnd, rnd[31:16]);
    end
    check("pins out", pins_out, rnd[15:0]);
    check("pins test", pins_test, 1'b1);
    ir(INS_PROG_LOCK);
    check("lock ignored", locked, 1'b0);
    ir(INS_PROG_EN);
    check("prog mode", prog_mode, 1'b1);
    // Two columns written, then read back in the same order
    for (int k = 0; k < 4; k++) begin
      roll();
      ir(INS_ADDR_SHIFT);
      dr(ADDR_W, 128'(k % 2 + 4));
      if (k < 2) begin
        ir(INS_DATA_SHIFT);
        dr(COL_W, rnd);
        ir(INS_PROGRAM);
        mdl_col[k + 4] = rnd[88:0];
        check("column writes", busy_cnt, k + 1);
      end else begin
        ir(INS_VERIFY);
        scan_rd("verify", INS_DATA_SHIFT, COL_W, '0, mdl_col[k + 2]);
      end
    end
    roll();
    ir(INS_SIGREAD);
    dr(SIG_W, rnd);
    ir(INS_PROG_SIG);
    mdl_sig = rnd[31:0];
    ir(INS_PROG_LOCK);
    check("locked", locked, 1'b1);
    scan_rd("signature", INS_SIGREAD, SIG_W, '0, mdl_sig[31:0]);
    scan_rd("id locked", INS_IDREAD, ID_W, '0, ID_WORD);
    scan_rd("refused readout", INS_DATA_SHIFT, COL_W, '0, '0);
    ir(INS_BULK_ERASE);
    check("lock cleared", locked, 1'b0);
    ir(INS_PROG_DIS);
    check("prog mode off", prog_mode, 1'b0);
    end_sim();
  end

  // The sequence needs about half a millisecond; four times that is a hang
  initial begin
    #2_000_000;
    err_count++;
    end_sim();
  end
endmodule

// file: verilog/jtcfg_fifo.sv
// FIFO with valid and ready on both sides
`timescale 1ns/1ps
module jtcfg_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  assign in_ready_o  = (cnt_reg != (AW+1)'(D));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem[rp_reg];
  assign push = in_valid_i && in_ready_o && ce_i;
  assign pop  = out_valid_o && out_ready_i && ce_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        mem[wp_reg] <= in_data_i;
        wp_reg      <= (wp_reg == AW'(D - 1)) ? '0 : wp_reg + AW'(1);
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(D - 1)) ? '0 : rp_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: verilog/jtcfg_pkg.sv
// Package: constants and types for the test access and configuration port
package jtcfg_pkg;

  // Instruction register
  localparam int unsigned IR_W = 8;
  localparam logic [7:0] INS_EXTEST      = 8'h00;
  localparam logic [7:0] INS_ADDR_SHIFT  = 8'h01;
  localparam logic [7:0] INS_DATA_SHIFT  = 8'h02;
  localparam logic [7:0] INS_BULK_ERASE  = 8'h03;
  localparam logic [7:0] INS_PROGRAM     = 8'h07;
  localparam logic [7:0] INS_PROG_LOCK   = 8'h09;
  localparam logic [7:0] INS_VERIFY      = 8'h0A;
  localparam logic [7:0] INS_PROG_EN     = 8'h15;
  localparam logic [7:0] INS_IDREAD      = 8'h16;
  localparam logic [7:0] INS_SIGREAD     = 8'h17;
  localparam logic [7:0] INS_PROG_SIG    = 8'h1A;
  localparam logic [7:0] INS_PROG_DIS    = 8'h1E;
  localparam logic [7:0] INS_SAMPLE      = 8'h1C;
  localparam int unsigned IR_MSB = 7;

  // Data register widths, column count and column index width
  localparam int unsigned ID_W   = 32;
  localparam int unsigned SIG_W  = 32;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned COL_W  = 89;
  localparam int unsigned BSR_W  = 16;
  localparam int unsigned SR_W   = 89;
  localparam int unsigned NCOL   = 16;
  localparam int unsigned CIDX_W = 4;

  // Identification word: arbitrary neutral value
  localparam logic [31:0] ID_WORD = 32'h0000_1001;
  // Capture value of the instruction stage
  localparam logic [7:0] IR_CAPTURE = INS_IDREAD;

  // FIFO between the scan stage and the nonvolatile write path
  localparam int unsigned FIFO_W = 89;
  localparam int unsigned FIFO_D = 8;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } jtcfg_state_type;

  typedef enum logic [1:0] {OP_NONE, OP_PROGRAM, OP_ERASE, OP_VERIFY} jtcfg_op_type;

endpackage

// file: verilog/jtcfg_top.sv
// Test access port with configuration memory programming, sampled on the system clock
`timescale 1ns/1ps
module jtcfg_top
  import jtcfg_pkg::*;
(
  input  wire logic              CLOCK_I,
  input  wire logic              NRST_I,
  input  wire logic              CE_I,
  input  wire logic              TCK_I,
  input  wire logic              TMS_I,
  input  wire logic              TDI_I,
  input  wire logic [BSR_W-1:0]  PINS_I,
  output logic                   TDO_O,
  output logic                   TDO_OE_N_O,
  output logic [BSR_W-1:0]       PINS_O,
  output logic                   PINS_TEST_O,
  output logic                   PROG_MODE_O,
  output logic                   LOCKED_O,
  output logic                   BUSY_O
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0]           tck_s;
    logic [1:0]           tms_s;
    logic [1:0]           tdi_s;
    logic [BSR_W-1:0]     pin_s0;
    logic [BSR_W-1:0]     pin_s1;
    jtcfg_state_type      st;
    logic [IR_W-1:0]      ir_sh;
    logic [IR_W-1:0]      ir;
    logic [SR_W-1:0]      dr;
    logic                 tdo;
    logic                 tdo_oe_n;
    logic [ADDR_W-1:0]    addr;
    logic [COL_W-1:0]     col;
    logic [SIG_W-1:0]     sig_stage;
    logic [SIG_W-1:0]     sig_nv;
    logic                 lock_nv;
    logic                 prog_mode;
    jtcfg_op_type         pend;
    logic                 wr_busy;
    logic [CIDX_W-1:0]    wr_idx;
    logic [BSR_W-1:0]     bsr;
    logic [BSR_W-1:0]     pins;
    logic                 pins_test;
  } jtcfg_core_type;

  jtcfg_core_type s_reg;
  jtcfg_core_type s_next;

  // Configuration array, written from the FIFO drain side
  logic [COL_W-1:0] cfg_mem [NCOL];

  logic             tck_rise;
  logic             tck_fall;
  logic             tms;
  logic             tdi;
  logic             fifo_ready;
  logic [FIFO_W-1:0] fifo_q;
  logic             fifo_valid;
  logic             fifo_pop;
  logic             fifo_push;
  logic [FIFO_W-1:0] fifo_d;
  logic             sel_bypass;

  // Sync stage 0 is only read by stage 1
  assign tck_rise = s_reg.tck_s[1] && !s_reg.tck_s[2];
  assign tck_fall = !s_reg.tck_s[1] && s_reg.tck_s[2];
  assign tms      = s_reg.tms_s[1];
  assign tdi      = s_reg.tdi_s[1];
  assign sel_bypass = s_reg.ir[IR_MSB];

  // Writes drain slowly: a pop sets busy for one cycle, so at most one write per two cycles
  assign fifo_pop = fifo_valid && !s_reg.wr_busy;

  jtcfg_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .clk_i       (CLOCK_I),
    .rst_n_i     (NRST_I),
    .ce_i        (CE_I),
    .in_data_i   (fifo_d),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_ready),
    .out_data_o  (fifo_q),
    .out_valid_o (fifo_valid),
    .out_ready_i (!s_reg.wr_busy)
  );

  always_ff @(posedge CLOCK_I) begin
    if (CE_I && fifo_pop) begin
      cfg_mem[fifo_q[CIDX_W-1:0]] <= s_reg.col;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    fifo_push = 1'b0;
    fifo_d = '0;
    s_next.tck_s = {s_reg.tck_s[1:0], TCK_I};
    s_next.tms_s = {s_reg.tms_s[0], TMS_I};
    s_next.tdi_s = {s_reg.tdi_s[0], TDI_I};
    // Pin levels are asynchronous to the system clock
    s_next.pin_s0 = PINS_I;
    s_next.pin_s1 = s_reg.pin_s0;
    if (s_reg.wr_busy) begin
      s_next.wr_busy = 1'b0;
    end
    if (fifo_pop) begin
      s_next.wr_busy = 1'b1;
    end

    if (tck_rise) begin
      // Actions of the state being left
      unique case (s_reg.st)
        ST_CAP_DR: begin
          if (sel_bypass) begin
            s_next.dr = '0;
          end else begin
            unique case (s_reg.ir)
              INS_ADDR_SHIFT: s_next.dr = SR_W'(s_reg.addr);
              INS_DATA_SHIFT, INS_VERIFY:
                s_next.dr = s_reg.lock_nv ? '0 : s_reg.col;
              INS_SIGREAD:    s_next.dr = SR_W'(s_reg.sig_nv);
              INS_EXTEST, INS_SAMPLE: s_next.dr = SR_W'(s_reg.pin_s1);
              default:        s_next.dr = SR_W'(ID_WORD);
            endcase
          end
        end
        ST_SH_DR: begin
          if (sel_bypass) begin
            s_next.dr[0] = tdi;
          end else begin
            unique case (s_reg.ir)
              INS_ADDR_SHIFT: s_next.dr = SR_W'({tdi, s_reg.dr[ADDR_W-1:1]});
              INS_DATA_SHIFT, INS_VERIFY: s_next.dr = {tdi, s_reg.dr[SR_W-1:1]};
              INS_EXTEST, INS_SAMPLE: s_next.dr = SR_W'({tdi, s_reg.dr[BSR_W-1:1]});
              default:        s_next.dr = SR_W'({tdi, s_reg.dr[ID_W-1:1]});
            endcase
          end
        end
        ST_CAP_IR: s_next.ir_sh = IR_CAPTURE;
        ST_SH_IR:  s_next.ir_sh = {tdi, s_reg.ir_sh[IR_W-1:1]};
        default: ;
      endcase

      // Transitions
      unique case (s_reg.st)
        ST_RESET:  s_next.st = tms ? ST_RESET : ST_IDLE;
        ST_IDLE:   s_next.st = tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: s_next.st = tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: s_next.st = tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR:  s_next.st = tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: s_next.st = tms ? ST_UPD_DR : ST_PAU_DR;
        ST_PAU_DR: s_next.st = tms ? ST_EX2_DR : ST_PAU_DR;
        ST_EX2_DR: s_next.st = tms ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: s_next.st = tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: s_next.st = tms ? ST_RESET : ST_CAP_IR;
        ST_CAP_IR: s_next.st = tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR:  s_next.st = tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: s_next.st = tms ? ST_UPD_IR : ST_PAU_IR;
        ST_PAU_IR: s_next.st = tms ? ST_EX2_IR : ST_PAU_IR;
        ST_EX2_IR: s_next.st = tms ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: s_next.st = tms ? ST_SEL_DR : ST_IDLE;
      endcase

      // Update actions take effect here
      if (s_reg.st == ST_UPD_IR) begin
        s_next.ir = s_reg.ir_sh;
        s_next.pend = OP_NONE;
        if (s_reg.prog_mode && !s_reg.ir_sh[IR_MSB]) begin
          unique case (s_reg.ir_sh)
            INS_PROGRAM, INS_PROG_LOCK, INS_PROG_SIG: s_next.pend = OP_PROGRAM;
            INS_BULK_ERASE: s_next.pend = OP_ERASE;
            INS_VERIFY:     s_next.pend = OP_VERIFY;
            default:        s_next.pend = OP_NONE;
          endcase
        end
        // Remaining instructions act at update
        unique case (s_reg.ir_sh)
          INS_PROG_EN:  s_next.prog_mode = 1'b1;
          INS_PROG_DIS: s_next.prog_mode = 1'b0;
          INS_SIGREAD:  s_next.sig_stage = s_reg.sig_nv;
          default: ;
        endcase
        s_next.pins_test = (s_reg.ir_sh == INS_EXTEST);
      end
      if (s_reg.st == ST_UPD_DR && !sel_bypass) begin
        unique case (s_reg.ir)
          INS_ADDR_SHIFT: s_next.addr = s_reg.dr[ADDR_W-1:0];
          INS_DATA_SHIFT: s_next.col = s_reg.dr[COL_W-1:0];
          INS_SIGREAD:    s_next.sig_stage = s_reg.dr[SIG_W-1:0];
          INS_EXTEST, INS_SAMPLE: s_next.bsr = s_reg.dr[BSR_W-1:0];
          default: ;
        endcase
      end

      // Pending operation starts on entry into run/idle
      // Next values, so an instruction latched on this very edge still runs
      if (s_next.st == ST_IDLE && s_reg.st != ST_IDLE) begin
        unique case (s_next.pend)
          OP_PROGRAM: begin
            unique case (s_next.ir)
              INS_PROG_LOCK: s_next.lock_nv = 1'b1;
              INS_PROG_SIG:  s_next.sig_nv = s_reg.sig_stage;
              default: begin
                fifo_push = fifo_ready;
                fifo_d = FIFO_W'(s_reg.addr);
              end
            endcase
          end
          OP_ERASE: begin
            s_next.lock_nv = 1'b0;
            s_next.sig_nv = '0;
          end
          OP_VERIFY: s_next.col = s_reg.lock_nv ? '0 : cfg_mem[s_reg.addr[CIDX_W-1:0]];
          OP_NONE: ;
        endcase
        // A refused push keeps the operation pending for the next entry
        if (!(s_next.pend == OP_PROGRAM && fifo_push == 1'b0
              && s_next.ir != INS_PROG_LOCK && s_next.ir != INS_PROG_SIG)) begin
          s_next.pend = OP_NONE;
        end
      end

      if (s_next.st == ST_RESET) begin
        s_next.ir = IR_CAPTURE;
        s_next.pend = OP_NONE;
        s_next.pins_test = 1'b0;
      end
    end

    if (tck_fall) begin
      s_next.tdo_oe_n = !(s_reg.st == ST_SH_DR || s_reg.st == ST_SH_IR);
      s_next.tdo = (s_reg.st == ST_SH_IR) ? s_reg.ir_sh[0] : s_reg.dr[0];
    end
    s_next.pins = s_reg.bsr;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      s_reg <= '0;
      s_reg.st <= ST_RESET;
      s_reg.ir <= IR_CAPTURE;
      s_reg.ir_sh <= IR_CAPTURE;
      s_reg.tdo_oe_n <= 1'b1;
    end else if (CE_I) begin
      s_reg <= s_next;
    end
  end

  assign TDO_O       = s_reg.tdo;
  assign TDO_OE_N_O  = s_reg.tdo_oe_n;
  assign PINS_O      = s_reg.pins;
  assign PINS_TEST_O = s_reg.pins_test;
  assign PROG_MODE_O = s_reg.prog_mode;
  assign LOCKED_O    = s_reg.lock_nv;
  assign BUSY_O      = s_reg.wr_busy;

endmodule
